// [inc/ipcw_pkg.sv]
// constants and state types for the interrupt priority, configuration and wake block
package ipcw_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 2;
  localparam int NUM_SRC = 11;
  localparam int SRC_W = 4;
  localparam int NUM_PLAIN = 12;

  // ****************************************
  // register word offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_PRIO_0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PRIO_1 = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_PLAIN_FIRST = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_PLAIN_LAST = 5'h0d;
  localparam logic [ADDR_W-1:0] OFS_VECTOR_BASE = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_PENDING_0 = 5'h0e;
  localparam logic [ADDR_W-1:0] OFS_PENDING_3 = 5'h11;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h16;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [DATA_W-1:0] PRIO_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] PLAIN_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] PRIO_0_MASK = 16'hf3ff;
  localparam logic [DATA_W-1:0] PRIO_1_MASK = 16'hc03f;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

  // ****************************************
  // field positions (lsb of each two-bit field)
  // ****************************************
  localparam int LSB_CLK_SYNTH = 14;
  localparam int LSB_LOW_VOLT = 12;
  localparam int LSB_DBG_RX = 8;
  localparam int LSB_DBG_TX = 6;
  localparam int LSB_DBG_TRACE = 4;
  localparam int LSB_DBG_BKPT = 2;
  localparam int LSB_DBG_STEP = 0;
  localparam int LSB_PORT_D = 14;
  localparam int LSB_FLASH_EMPTY = 4;
  localparam int LSB_FLASH_DONE = 2;
  localparam int LSB_FLASH_FAULT = 0;

  // ****************************************
  // source numbers, lower number more urgent within one level
  // ****************************************
  localparam logic [SRC_W-1:0] SRC_CLK_SYNTH = 4'h0;
  localparam logic [SRC_W-1:0] SRC_LOW_VOLT = 4'h1;
  localparam logic [SRC_W-1:0] SRC_DBG_RX = 4'h2;
  localparam logic [SRC_W-1:0] SRC_DBG_TX = 4'h3;
  localparam logic [SRC_W-1:0] SRC_DBG_TRACE = 4'h4;
  localparam logic [SRC_W-1:0] SRC_DBG_BKPT = 4'h5;
  localparam logic [SRC_W-1:0] SRC_DBG_STEP = 4'h6;
  localparam logic [SRC_W-1:0] SRC_PORT_D = 4'h7;
  localparam logic [SRC_W-1:0] SRC_FLASH_EMPTY = 4'h8;
  localparam logic [SRC_W-1:0] SRC_FLASH_DONE = 4'h9;
  localparam logic [SRC_W-1:0] SRC_FLASH_FAULT = 4'ha;
  // sources at or above this number use the levels zero to two encoding
  localparam logic [SRC_W-1:0] SRC_FIRST_LOW = 4'h7;

  // ****************************************
  // field and presented level encodings
  // ****************************************
  localparam logic [FIELD_W-1:0] FIELD_OFF = 2'h0;
  localparam logic [FIELD_W-1:0] LEVEL_ONE = 2'h1;
  localparam logic [FIELD_W-1:0] LEVEL_TWO = 2'h2;
  localparam logic [FIELD_W-1:0] PRES_NONE = 2'h0;
  localparam logic [FIELD_W-1:0] PRES_L0 = 2'h1;
  localparam logic [FIELD_W-1:0] PRES_L1 = 2'h2;
  localparam logic [FIELD_W-1:0] PRES_L23 = 2'h3;

  typedef struct packed {
    logic [DATA_W-1:0] prio0;
    logic [DATA_W-1:0] prio1;
    logic [NUM_PLAIN-1:0][DATA_W-1:0] plain;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic [FIELD_W-1:0] level;
    logic [FIELD_W-1:0] pres;
    logic [SRC_W-1:0] src;
    logic [NUM_SRC-1:0] wake_en;
  } ipcw_state_t;

endpackage : ipcw_pkg

// [rtl/ipcw_top.sv]
// priority configuration, arbitration and wake request logic of the interrupt controller
`timescale 1ns/1ps
//
// Summary of operation
// - Functional mode is the default after reset; nothing to configure.
// - In wait or stop, any pending request from a source enabled on entry raises the wake output.
// - Only sources enabled before entering wait or stop may wake the core.
// - Registers decode at word offsets: priorities 0-1, vector base 7, control 0x16.
// - Every two-bit priority field resets to zero, meaning request disabled.
// - Levels one-to-three sources: 01 level 1, 10 level 2, 11 level 3.
// - Levels zero-to-two sources: 01 level 0, 10 level 1, 11 level 2.
// - Priority 0 bits 15-14: clock synthesizer loss or lock change level.
// - Priority 0 bits 13-12: low voltage detector level.
// - Priority 0 bits 9-8: debug receive register full level.
// - Priority 0 bits 7-6: debug transmit register empty level.
// - Priority 0 bits 5-4: debug trace buffer level.
// - Priority 0 bits 3-2: debug breakpoint unit level.
// - Priority 0 bits 1-0: debug step counter level.
// - Priority 1 bits 15-14: port D pin level.
// - Priority 1 bits 5-4: flash buffers empty level.
// - Priority 1 bits 3-2: flash command complete level.
// - Priority 1 bits 1-0: flash error level.
// - Within one level, the lowest source number wins.

module ipcw_top
  import ipcw_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // request sources, indexed by source number
  input wire logic [NUM_SRC-1:0] src_req_in,
  // power state from the system integration unit
  input wire logic low_power_in,
  // core side
  output logic irq_out,
  output logic [FIELD_W-1:0] irq_level_out,
  output logic [FIELD_W-1:0] irq_presented_out,
  output logic [SRC_W-1:0] irq_source_out,
  // wake request to the system integration unit
  output logic wake_out
);

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic [FIELD_W-1:0] field_of(input logic [DATA_W-1:0] p0,
                                                  input logic [DATA_W-1:0] p1,
                                                  input logic [SRC_W-1:0] s);
    logic [FIELD_W-1:0] f;
    f = FIELD_OFF;
    case (s)
      SRC_CLK_SYNTH: f = p0[LSB_CLK_SYNTH +: FIELD_W];
      SRC_LOW_VOLT: f = p0[LSB_LOW_VOLT +: FIELD_W];
      SRC_DBG_RX: f = p0[LSB_DBG_RX +: FIELD_W];
      SRC_DBG_TX: f = p0[LSB_DBG_TX +: FIELD_W];
      SRC_DBG_TRACE: f = p0[LSB_DBG_TRACE +: FIELD_W];
      SRC_DBG_BKPT: f = p0[LSB_DBG_BKPT +: FIELD_W];
      SRC_DBG_STEP: f = p0[LSB_DBG_STEP +: FIELD_W];
      SRC_PORT_D: f = p1[LSB_PORT_D +: FIELD_W];
      SRC_FLASH_EMPTY: f = p1[LSB_FLASH_EMPTY +: FIELD_W];
      SRC_FLASH_DONE: f = p1[LSB_FLASH_DONE +: FIELD_W];
      SRC_FLASH_FAULT: f = p1[LSB_FLASH_FAULT +: FIELD_W];
      default: f = FIELD_OFF;
    endcase
    return f;
  endfunction : field_of

  // field to absolute level; only meaningful when the field is not off
  function automatic logic [FIELD_W-1:0] level_of(input logic [FIELD_W-1:0] f,
                                                  input logic [SRC_W-1:0] s);
    logic [FIELD_W-1:0] l;
    l = f;
    if (s >= SRC_FIRST_LOW) begin
      l = FIELD_W'(f - LEVEL_ONE);
    end
    return l;
  endfunction : level_of

  // level to the code the core compares against its mask
  function automatic logic [FIELD_W-1:0] present_of(input logic any,
                                                    input logic [FIELD_W-1:0] l);
    logic [FIELD_W-1:0] p;
    p = PRES_NONE;
    if (any) begin
      case (l)
        FIELD_OFF: p = PRES_L0;
        LEVEL_ONE: p = PRES_L1;
        default: p = PRES_L23;
      endcase
    end
    return p;
  endfunction : present_of

  // ****************************************
  // state
  // ****************************************
  ipcw_state_t state;
  ipcw_state_t next_state;

  logic [NUM_SRC-1:0] src_enabled;
  logic [FIELD_W-1:0] src_field [NUM_SRC];
  logic [FIELD_W-1:0] src_level [NUM_SRC];

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      assign src_field[g] = field_of(state.prio0, state.prio1, SRC_W'(g));
      assign src_level[g] = level_of(src_field[g], SRC_W'(g));
      assign src_enabled[g] = (src_field[g] != FIELD_OFF);
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic found;
    logic [FIELD_W-1:0] best_lvl;
    logic [SRC_W-1:0] best_src;
    logic [ADDR_W-1:0] plain_idx;
    logic [DATA_W-1:0] rd;
    found = 1'b0;
    best_lvl = FIELD_OFF;
    best_src = SRC_CLK_SYNTH;
    plain_idx = ADDR_W'(reg_addr_in - OFS_PLAIN_FIRST);
    rd = READ_ZERO;
    next_state = state;

    // register writes; reserved bits are masked off
    if (reg_wr_in) begin
      if (reg_addr_in == OFS_PRIO_0) begin
        next_state.prio0 = reg_wdata_in & PRIO_0_MASK;
      end else if (reg_addr_in == OFS_PRIO_1) begin
        next_state.prio1 = reg_wdata_in & PRIO_1_MASK;
      end else if (reg_addr_in >= OFS_PLAIN_FIRST && reg_addr_in <= OFS_PLAIN_LAST) begin
        next_state.plain[plain_idx] = reg_wdata_in;
      end
    end

    // register reads, registered one cycle after the strobe
    if (reg_addr_in == OFS_PRIO_0) begin
      rd = state.prio0 & PRIO_0_MASK;
    end else if (reg_addr_in == OFS_PRIO_1) begin
      rd = state.prio1 & PRIO_1_MASK;
    end else if (reg_addr_in >= OFS_PLAIN_FIRST && reg_addr_in <= OFS_PLAIN_LAST) begin
      rd = state.plain[plain_idx];
    end else if (reg_addr_in == OFS_PENDING_0) begin
      rd = DATA_W'(src_req_in & src_enabled);
    end else if (reg_addr_in == OFS_CONTROL) begin
      rd = DATA_W'(state.pres);
    end
    if (reg_rd_in) begin
      next_state.rdata = rd;
    end

    // highest level wins; strict compare keeps the lowest number on a tie
    for (int i = 0; i < NUM_SRC; i++) begin
      if (src_req_in[i] && src_enabled[i]) begin
        if (!found || src_level[i] > best_lvl) begin
          found = 1'b1;
          best_lvl = src_level[i];
          best_src = SRC_W'(i);
        end
      end
    end
    next_state.irq = found;
    next_state.level = best_lvl;
    next_state.src = best_src;
    next_state.pres = present_of(found, best_lvl);

    // enables frozen on entry; clocks stop once low power is reached
    if (!low_power_in) begin
      next_state.wake_en = src_enabled;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state.prio0 <= PRIO_RESET;
      state.prio1 <= PRIO_RESET;
      state.plain <= {NUM_PLAIN{PLAIN_RESET}};
      state.rdata <= READ_ZERO;
      state.irq <= 1'b0;
      state.level <= FIELD_OFF;
      state.pres <= PRES_NONE;
      state.src <= SRC_CLK_SYNTH;
      state.wake_en <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata_out = state.rdata;
  assign irq_out = state.irq;
  assign irq_level_out = state.level;
  assign irq_presented_out = state.pres;
  assign irq_source_out = state.src;
  // combinational on purpose: no clock runs to register it in wait or stop
  assign wake_out = low_power_in && |(src_req_in & state.wake_en);

endmodule : ipcw_top

// [test/ipcw_asserts.sv]
// property checks on the ports of the interrupt priority and wake block
`timescale 1ns/1ps
module ipcw_asserts
  import ipcw_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  // requests, power and core side
  input wire logic [NUM_SRC-1:0] src_req_in,
  input wire logic low_power_in,
  input wire logic irq_out,
  input wire logic [FIELD_W-1:0] irq_level_out,
  input wire logic [FIELD_W-1:0] irq_presented_out,
  input wire logic [SRC_W-1:0] irq_source_out,
  input wire logic wake_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_awake; !low_power_in |-> !wake_out; endproperty
  a_awake: assert property (p_awake) else $error("wake outside low power");
  property p_wcause; wake_out |-> (src_req_in != 11'h000); endproperty
  a_wcause: assert property (p_wcause) else $error("wake without request");
  property p_rst; $rose(resetn_in) |-> !irq_out && reg_rdata_out == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_src; irq_out |-> |($past(src_req_in) & (11'h001 << irq_source_out)); endproperty
  a_src: assert property (p_src) else $error("winner was not requesting");
  property p_quiet; src_req_in == 11'h000 |=> !irq_out; endproperty
  a_quiet: assert property (p_quiet) else $error("request shown with none raised");
  property p_pres;
    irq_presented_out == (!irq_out ? PRES_NONE :
      (irq_level_out > 2'h1 ? PRES_L23 : irq_level_out + 2'h1));
  endproperty
  a_pres: assert property (p_pres) else $error("presented code wrong");
  property p_hi; irq_out && irq_source_out < SRC_FIRST_LOW |-> irq_level_out != 2'h0; endproperty
  a_hi: assert property (p_hi) else $error("level zero on upper source");
  property p_lo; irq_out && irq_source_out >= SRC_FIRST_LOW |-> irq_level_out != 2'h3; endproperty
  a_lo: assert property (p_lo) else $error("level three on lower source");
  property p_resv;
    reg_rd_in && reg_addr_in == OFS_PRIO_1 |=> (reg_rdata_out & ~PRIO_1_MASK) == 16'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read set");
  c_irq: cover property (irq_out);
  c_wake: cover property (wake_out);
  c_top: cover property (irq_presented_out == PRES_L23);
endmodule : ipcw_asserts

bind ipcw_top ipcw_asserts u_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .src_req_in(src_req_in),
  .low_power_in(low_power_in), .irq_out(irq_out), .irq_level_out(irq_level_out),
  .irq_presented_out(irq_presented_out), .irq_source_out(irq_source_out),
  .wake_out(wake_out));

// [test/ipcw_sim_model.sv]
// behavioural system integration unit: sleep entry and clock restart
`timescale 1ns/1ps
module ipcw_sim_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // sleep order from bench, wake from block
  input wire logic sleep_in,
  input wire logic wake_in,
  // power state to block
  output logic low_power_out
);
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_power_out <= 1'b0;
    end else if (sleep_in) begin
      low_power_out <= 1'b1;
    end else if (wake_in) begin
      low_power_out <= 1'b0;
    end
  end
endmodule : ipcw_sim_model

// [test/irq_priority_config_wake_tb.sv]
// self-checking bench for the interrupt priority and wake block
`timescale 1ns/1ps
module irq_priority_config_wake_tb;
  import ipcw_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr = 5'h00;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [NUM_SRC-1:0] req = 11'h000;
  logic sleep = 1'b0;
  logic low_power, irq, wake;
  logic [DATA_W-1:0] rdata;
  logic [FIELD_W-1:0] level, pres;
  logic [SRC_W-1:0] src;
  int n_fail = 0;
  int samples_checked = 0;
  always #12.5 clk_in = ~clk_in;
  ipcw_top uut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .src_req_in(req), .low_power_in(low_power), .irq_out(irq), .irq_level_out(level),
    .irq_presented_out(pres), .irq_source_out(src), .wake_out(wake));
  ipcw_sim_model sim (.clk_in(clk_in), .resetn_in(resetn_in), .sleep_in(sleep),
    .wake_in(wake), .low_power_out(low_power));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : rd_reg
  task automatic see(input logic [3:0] s, input logic [1:0] l);
    @(posedge clk_in);
    #1;
    chk("irq_request", 1'b1, irq);
    chk("irq_source", s, src);
    chk("irq_level", l, level);
    chk("irq_presented", (l > 2'h1) ? 2'h3 : l + 2'h1, pres);
  endtask : see
  task automatic t_regs;
    rd_reg(5'h00, 16'h0000, "prio0 reset");
    rd_reg(5'h16, 16'h0000, "control idle");
    wr_reg(5'h00, 16'hf3ff);
    rd_reg(5'h00, 16'hf3ff, "prio0 fields");
    wr_reg(5'h01, 16'hc03f);
    rd_reg(5'h01, 16'hc03f, "prio1 fields");
    wr_reg(5'h07, 16'ha5c3);
    rd_reg(5'h07, 16'ha5c3, "vector base");
    wr_reg(5'h13, 16'hffff);
    rd_reg(5'h13, 16'h0000, "unmapped");
  endtask : t_regs
  task automatic t_levels;
    int lsb[11] = '{14, 12, 8, 6, 4, 2, 0, 14, 4, 2, 0};
    logic [1:0] f;
    for (int s = 0; s < 11; s++) begin
      for (int v = 1; v < 4; v++) begin
        f = v[1:0];
        wr_reg(s < 7 ? 5'h00 : 5'h01, 16'(f) << lsb[s]);
        req <= 11'h001 << s;
        see(s[3:0], s < 7 ? f : f - 2'h1);
        req <= 11'h000;
      end
    end
  endtask : t_levels
  task automatic t_tie;
    wr_reg(5'h00, 16'h0280);
    wr_reg(5'h01, 16'hc000);
    req <= 11'h08c;
    see(4'h2, 2'h2);
    req <= 11'h088;
    see(4'h3, 2'h2);
    req <= 11'h080;
    see(4'h7, 2'h2);
    rd_reg(5'h0e, 16'h0080, "pending 0");
    rd_reg(5'h16, 16'h0003, "control presented");
    req <= 11'h000;
  endtask : t_tie
  task automatic t_wake;
    wr_reg(5'h00, 16'h0000);
    wr_reg(5'h01, 16'h4000);
    sleep <= 1'b1;
    @(posedge clk_in);
    sleep <= 1'b0;
    wr_reg(5'h01, 16'h4010);
    req <= 11'h100;
    #1;
    chk("wake disabled", 1'b0, wake);
    @(posedge clk_in);
    req <= 11'h180;
    #1;
    chk("wake enabled", 1'b1, wake);
    for (int i = 0; i < 4 && low_power; i++) @(posedge clk_in);
    #1;
    chk("clocks restarted", 1'b0, low_power);
    if (low_power) begin
      finish_test();
    end
    req <= 11'h000;
  endtask : t_wake
  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_regs();
    t_levels();
    t_tie();
    t_wake();
    finish_test();
  end
endmodule : irq_priority_config_wake_tb
